//--- src/ppr_consts.vh
// Register offsets, field positions and reset values of the pin remap block
`ifndef PPR_CONSTS_VH
`define PPR_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PPR_ADDR_IN_REMAP 8'h00
`define PPR_ADDR_OUT_REMAP 8'h01
`define PPR_ADDR_TM_EN0 8'h02
`define PPR_ADDR_TM_EN1 8'h03
`define PPR_ADDR_WAKE_EN 8'h04
`define PPR_ADDR_BITOP 8'h05
`define PPR_ADDR_DATA_BASE 8'h10
`define PPR_ADDR_DIR_BASE 8'h18
`define PPR_ADDR_PIN_BASE 8'h20

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PPR_REMAP_RST 8'h00
`define PPR_PORT_RST 8'hff
`define PPR_TM_EN_RST 8'h00
`define PPR_WAKE_EN_RST 8'h00
`define PPR_RDATA_RST 8'h00

// ----------------------------------------------------------------
// Implemented-bit masks per variant (0 smallest .. 3 largest)
// ----------------------------------------------------------------
`define PPR_OUT_MASK_V0 8'h07
`define PPR_OUT_MASK_V1 8'h3f
`define PPR_OUT_MASK_V2 8'hff
`define PPR_IN_MASK_V0 8'h6f
`define PPR_IN_MASK_V1 8'hef
`define PPR_IN_MASK_V3 8'hff
`define PPR_TM_EN1_MASK 8'h1f

// ----------------------------------------------------------------
// Input remap fields
// ----------------------------------------------------------------
`define PPR_IN_TCLK2 7
`define PPR_IN_TCLK1 6
`define PPR_IN_TCLK0 5
`define PPR_IN_EXTIRQ2 4
`define PPR_IN_EXTIRQ1 3
`define PPR_IN_EXTIRQ0 2
`define PPR_IN_T1B_OUT1 1
`define PPR_IN_T1B_OUT0 0

// ----------------------------------------------------------------
// Timer output remap fields
// ----------------------------------------------------------------
`define PPR_OUT_T3_OUT1 7
`define PPR_OUT_T3_OUT0 6
`define PPR_OUT_T2_OUT1 5
`define PPR_OUT_T2_OUT0 4
`define PPR_OUT_T1B_OUT2 3
`define PPR_OUT_T1A_OUT 2
`define PPR_OUT_T0_OUT1 1
`define PPR_OUT_T0_OUT0 0

// ----------------------------------------------------------------
// Second enable register fields and bit-op command fields
// ----------------------------------------------------------------
`define PPR_EN1_TCLK0 2
`define PPR_EN1_TCLK1 3
`define PPR_EN1_TCLK2 4
`define PPR_BITOP_SET 7
`define PPR_BITOP_DIR 6
`define PPR_BITOP_PORT_LO 3
`define PPR_BITOP_BIT_LO 0

// ----------------------------------------------------------------
// Port letters
// ----------------------------------------------------------------
`define PPR_PORT_A 3'h0
`define PPR_PORT_C 3'h2
`define PPR_PORT_D 3'h3
`define PPR_PORT_E 3'h4
`define PPR_PORT_F 3'h5
`define PPR_PORT_G 3'h6

`endif

//--- src/ppr_pin_remap.v
// Pin remap multiplexer, general I/O port registers and port A wake-up
`default_nettype none
`include "ppr_consts.vh"

module ppr_pin_remap #(
	parameter [1:0] VARIANT = 2'd3,
	parameter [5:0] EXTIRQ2_PIN0 = 6'h05,
	parameter [5:0] EXTIRQ2_PIN1 = 6'h26
) (
	input wire clk_sys_in,
	input wire reset_in,
	input wire clk_en_in,
	input wire [7:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	output wire [7:0] reg_rdata_out,
	input wire [63:0] port_pin_in,
	output wire [63:0] port_pin_out,
	output wire [63:0] port_pin_oe_out,
	input wire timer0_out_ch0_in,
	input wire timer0_out_ch1_in,
	input wire timer1_a_out_in,
	input wire timer1_b_out_ch0_in,
	input wire timer1_b_out_ch1_in,
	input wire timer1_b_out_ch2_in,
	input wire timer2_out_ch0_in,
	input wire timer2_out_ch1_in,
	input wire timer3_out_ch0_in,
	input wire timer3_out_ch1_in,
	output wire timer0_clock_in_out,
	output wire timer1_clock_in_out,
	output wire timer2_clock_in_out,
	output wire ext_irq0_in_out,
	output wire ext_irq1_in_out,
	output wire ext_irq2_in_out,
	input wire sleep_mode_in,
	output wire wake_out
);

	// ----------------------------------------------------------------
	// Variant decode
	// ----------------------------------------------------------------
	wire smallest = (VARIANT == 2'd0);
	wire [7:0] out_mask = (VARIANT == 2'd0) ? `PPR_OUT_MASK_V0 :
		(VARIANT == 2'd1) ? `PPR_OUT_MASK_V1 : `PPR_OUT_MASK_V2;
	wire [7:0] in_mask = (VARIANT == 2'd0) ? `PPR_IN_MASK_V0 :
		(VARIANT == 2'd3) ? `PPR_IN_MASK_V3 : `PPR_IN_MASK_V1;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	reg [7:0] input_pin_remap_r;
	reg [7:0] timer_output_pin_remap_r;
	reg [7:0] tm_en0_r;
	reg [7:0] tm_en1_r;
	reg [7:0] wake_en_r;
	reg [63:0] port_data_regs_r;
	reg [63:0] port_direction_regs_r;
	reg [63:0] pin_meta_r;
	reg [63:0] pin_sync_r;
	reg [7:0] porta_prev_r;
	reg [7:0] rdata_r;
	reg [63:0] pin_out_r;
	reg [63:0] pin_oe_r;
	reg [5:0] route_in_r;
	reg wake_r;

	// ----------------------------------------------------------------
	// Pin index of each timer output, by function and select bit
	// ----------------------------------------------------------------
	function [5:0] out_pin;
		input [3:0] f;
		input s;
		input sm;
		begin
			case (f)
				4'h0: out_pin = s ? {`PPR_PORT_D, 3'h0} : {`PPR_PORT_A, 3'h0};
				4'h1: out_pin = s ? {`PPR_PORT_D, 3'h1} : (sm ? {`PPR_PORT_A, 3'h7} : {`PPR_PORT_C, 3'h5});
				4'h2: out_pin = s ? {`PPR_PORT_D, 3'h2} : {`PPR_PORT_A, 3'h1};
				// timer 1 B outputs 0 and 1
				4'h3: out_pin = s ? {`PPR_PORT_D, 3'h3} : {`PPR_PORT_C, 3'h0};
				4'h4: out_pin = s ? {`PPR_PORT_D, 3'h4} : {`PPR_PORT_C, 3'h1};
				4'h5: out_pin = s ? {`PPR_PORT_D, 3'h5} : {`PPR_PORT_C, 3'h5};
				4'h6: out_pin = s ? {`PPR_PORT_D, 3'h6} : {`PPR_PORT_C, 3'h3};
				4'h7: out_pin = s ? {`PPR_PORT_D, 3'h7} : {`PPR_PORT_C, 3'h4};
				4'h8: out_pin = s ? {`PPR_PORT_F, 3'h0} : {`PPR_PORT_G, 3'h3};
				4'h9: out_pin = s ? {`PPR_PORT_F, 3'h1} : {`PPR_PORT_G, 3'h0};
				default: out_pin = 6'h00;
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// Pin synchroniser
	// ----------------------------------------------------------------
	always @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			pin_meta_r <= {8{`PPR_PORT_RST}};
			pin_sync_r <= {8{`PPR_PORT_RST}};
		end
		else if (clk_en_in)
		begin
			pin_meta_r <= port_pin_in;
			pin_sync_r <= pin_meta_r;
		end
	end

	// ----------------------------------------------------------------
	// Bit set/clear command
	// ----------------------------------------------------------------
	wire [2:0] bop_port = reg_wdata_in[`PPR_BITOP_PORT_LO +: 3];
	wire [2:0] bop_bit = reg_wdata_in[`PPR_BITOP_BIT_LO +: 3];
	wire bop_dir = reg_wdata_in[`PPR_BITOP_DIR];
	wire bop_set = reg_wdata_in[`PPR_BITOP_SET];
	wire bop_go = reg_wr_in && (reg_addr_in == `PPR_ADDR_BITOP);
	// Data target reads pin levels, so other output bits may change
	wire [7:0] bop_read = bop_dir ? port_direction_regs_r[{bop_port, 3'h0} +: 8]
		: pin_sync_r[{bop_port, 3'h0} +: 8];
	reg [7:0] bop_byte;

	always @*
	begin
		bop_byte = bop_read;
		bop_byte[bop_bit] = bop_set;
	end

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	localparam [7:0] DATA_BASE = `PPR_ADDR_DATA_BASE;
	localparam [7:0] DIR_BASE = `PPR_ADDR_DIR_BASE;
	localparam [7:0] PIN_BASE = `PPR_ADDR_PIN_BASE;
	wire wr_data = reg_wr_in && (reg_addr_in[7:3] == DATA_BASE[7:3]);
	wire wr_dir = reg_wr_in && (reg_addr_in[7:3] == DIR_BASE[7:3]);
	wire [2:0] wr_port = reg_addr_in[2:0];

	always @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			input_pin_remap_r <= `PPR_REMAP_RST;
			timer_output_pin_remap_r <= `PPR_REMAP_RST;
			tm_en0_r <= `PPR_TM_EN_RST;
			tm_en1_r <= `PPR_TM_EN_RST;
			wake_en_r <= `PPR_WAKE_EN_RST;
			port_data_regs_r <= {8{`PPR_PORT_RST}};
			port_direction_regs_r <= {8{`PPR_PORT_RST}};
		end
		else if (clk_en_in && reg_wr_in)
		begin
			if (reg_addr_in == `PPR_ADDR_IN_REMAP)
				input_pin_remap_r <= reg_wdata_in & in_mask;
			if (reg_addr_in == `PPR_ADDR_OUT_REMAP)
				timer_output_pin_remap_r <= reg_wdata_in & out_mask;
			if (reg_addr_in == `PPR_ADDR_TM_EN0)
				tm_en0_r <= reg_wdata_in;
			if (reg_addr_in == `PPR_ADDR_TM_EN1)
				tm_en1_r <= reg_wdata_in & `PPR_TM_EN1_MASK;
			if (reg_addr_in == `PPR_ADDR_WAKE_EN)
				wake_en_r <= reg_wdata_in;
			if (wr_data)
				port_data_regs_r[{wr_port, 3'h0} +: 8] <= reg_wdata_in;
			if (wr_dir)
				port_direction_regs_r[{wr_port, 3'h0} +: 8] <= reg_wdata_in;
			if (bop_go && !bop_dir)
				port_data_regs_r[{bop_port, 3'h0} +: 8] <= bop_byte;
			if (bop_go && bop_dir)
				port_direction_regs_r[{bop_port, 3'h0} +: 8] <= bop_byte;
		end
	end

	// ----------------------------------------------------------------
	// Register reads
	// ----------------------------------------------------------------
	reg [7:0] rd_val;

	always @*
	begin
		rd_val = 8'h00;
		case (reg_addr_in)
			`PPR_ADDR_IN_REMAP: rd_val = input_pin_remap_r;
			`PPR_ADDR_OUT_REMAP: rd_val = timer_output_pin_remap_r;
			`PPR_ADDR_TM_EN0: rd_val = tm_en0_r;
			`PPR_ADDR_TM_EN1: rd_val = tm_en1_r;
			`PPR_ADDR_WAKE_EN: rd_val = wake_en_r;
			default:
			begin
				if (reg_addr_in[7:3] == DATA_BASE[7:3])
					rd_val = port_data_regs_r[{reg_addr_in[2:0], 3'h0} +: 8];
				else if (reg_addr_in[7:3] == DIR_BASE[7:3])
					rd_val = port_direction_regs_r[{reg_addr_in[2:0], 3'h0} +: 8];
				else if (reg_addr_in[7:3] == PIN_BASE[7:3])
					rd_val = pin_sync_r[{reg_addr_in[2:0], 3'h0} +: 8];
			end
		endcase
	end

	always @(posedge clk_sys_in)
	begin
		if (reset_in)
			rdata_r <= `PPR_RDATA_RST;
		else if (clk_en_in)
			rdata_r <= reg_rd_in ? rd_val : `PPR_RDATA_RST;
	end

	// ----------------------------------------------------------------
	// Output pin multiplexer
	// ----------------------------------------------------------------
	wire [9:0] tm_out = {timer3_out_ch1_in, timer3_out_ch0_in, timer2_out_ch1_in, timer2_out_ch0_in,
		timer1_b_out_ch2_in, timer1_b_out_ch1_in, timer1_b_out_ch0_in, timer1_a_out_in,
		timer0_out_ch1_in, timer0_out_ch0_in};
	wire [7:0] orm = timer_output_pin_remap_r;
	wire [7:0] irm = input_pin_remap_r;
	wire [9:0] tm_sel = {orm[`PPR_OUT_T3_OUT1], orm[`PPR_OUT_T3_OUT0], orm[`PPR_OUT_T2_OUT1],
		orm[`PPR_OUT_T2_OUT0], orm[`PPR_OUT_T1B_OUT2], irm[`PPR_IN_T1B_OUT1], irm[`PPR_IN_T1B_OUT0],
		orm[`PPR_OUT_T1A_OUT], orm[`PPR_OUT_T0_OUT1], orm[`PPR_OUT_T0_OUT0]};
	// Timers missing on a variant never claim a pin
	wire [9:0] tm_avail = (VARIANT == 2'd0) ? 10'h01f : (VARIANT == 2'd1) ? 10'h0ff : 10'h3ff;
	wire [9:0] tm_en = {tm_en1_r[1:0], tm_en0_r} & tm_avail;
	reg [63:0] drv_val;
	reg [63:0] drv_oe;
	reg [5:0] pidx;
	integer i;

	always @*
	begin
		pidx = 6'h00;
		// output level is the data register
		drv_val = port_data_regs_r;
		drv_oe = ~port_direction_regs_r;
		// lowest function number applied last, so it wins
		for (i = 9; i >= 0; i = i - 1)
		begin
			if (tm_en[i])
			begin
				pidx = out_pin(i[3:0], tm_sel[i], smallest);
				drv_val[pidx] = tm_out[i];
				drv_oe[pidx] = 1'b1;
			end
		end
	end

	always @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			pin_out_r <= {8{`PPR_PORT_RST}};
			pin_oe_r <= 64'h0000000000000000;
		end
		else if (clk_en_in)
		begin
			pin_out_r <= drv_val;
			pin_oe_r <= drv_oe;
		end
	end

	// ----------------------------------------------------------------
	// Input routing
	// ----------------------------------------------------------------
	// timer clock and external interrupt pins
	wire tclk0 = irm[`PPR_IN_TCLK0] ? pin_sync_r[{`PPR_PORT_E, 3'h0}] : pin_sync_r[{`PPR_PORT_A, 3'h2}];
	wire tclk1 = irm[`PPR_IN_TCLK1] ? pin_sync_r[{`PPR_PORT_E, 3'h1}] : pin_sync_r[{`PPR_PORT_A, 3'h4}];
	wire tclk2 = irm[`PPR_IN_TCLK2] ? pin_sync_r[{`PPR_PORT_E, 3'h2}] : pin_sync_r[{`PPR_PORT_C, 3'h2}];
	wire irq0 = irm[`PPR_IN_EXTIRQ0] ? pin_sync_r[{`PPR_PORT_E, 3'h4}] : pin_sync_r[{`PPR_PORT_A, 3'h3}];
	wire irq1 = irm[`PPR_IN_EXTIRQ1] ? pin_sync_r[{`PPR_PORT_E, 3'h5}] : pin_sync_r[{`PPR_PORT_A, 3'h4}];
	wire irq2 = irm[`PPR_IN_EXTIRQ2] ? pin_sync_r[EXTIRQ2_PIN1] : pin_sync_r[EXTIRQ2_PIN0];

	always @(posedge clk_sys_in)
	begin
		if (reset_in)
			route_in_r <= 6'h00;
		else if (clk_en_in)
		begin
			route_in_r[0] <= tclk0 & tm_en1_r[`PPR_EN1_TCLK0];
			route_in_r[1] <= tclk1 & tm_en1_r[`PPR_EN1_TCLK1];
			route_in_r[2] <= tclk2 & tm_en1_r[`PPR_EN1_TCLK2] & (VARIANT != 2'd0);
			route_in_r[3] <= irq0;
			route_in_r[4] <= irq1;
			route_in_r[5] <= irq2 & (VARIANT == 2'd3);
		end
	end

	// ----------------------------------------------------------------
	// Port A wake-up
	// ----------------------------------------------------------------
	always @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			porta_prev_r <= `PPR_PORT_RST;
			wake_r <= 1'b0;
		end
		else if (clk_en_in)
		begin
			porta_prev_r <= pin_sync_r[7:0];
			wake_r <= sleep_mode_in && |(porta_prev_r & ~pin_sync_r[7:0] & wake_en_r);
		end
	end

	assign reg_rdata_out = rdata_r;
	assign port_pin_out = pin_out_r;
	assign port_pin_oe_out = pin_oe_r;
	assign timer0_clock_in_out = route_in_r[0];
	assign timer1_clock_in_out = route_in_r[1];
	assign timer2_clock_in_out = route_in_r[2];
	assign ext_irq0_in_out = route_in_r[3];
	assign ext_irq1_in_out = route_in_r[4];
	assign ext_irq2_in_out = route_in_r[5];
	assign wake_out = wake_r;

endmodule // ppr_pin_remap
`default_nettype wire

//--- tb/ppr_pin_env.sv
// External circuitry model on the shared port pins
`default_nettype none
module ppr_pin_env (
	input wire logic [63:0] pin_drv_in,
	input wire logic [63:0] pin_oe_in,
	input wire logic [63:0] ext_lvl_in,
	output logic [63:0] pin_lvl_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// Released pins show the outside level, never a stale drive
	assign pin_lvl_out = (pin_drv_in & pin_oe_in) | (ext_lvl_in & ~pin_oe_in);
endmodule // ppr_pin_env
`default_nettype wire

//--- tb/ppr_pin_remap_monitor.sv
// Assertion checker for the pin remap block, bound to it
`default_nettype none
`include "ppr_consts.vh"
module ppr_pin_remap_chk #(
	parameter [1:0] VARIANT = 2'd3
) (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic clk_en_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic [63:0] port_pin_in,
	input wire logic [63:0] port_pin_out,
	input wire logic [63:0] port_pin_oe_out,
	input wire logic timer0_out_ch0_in,
	input wire logic timer3_out_ch1_in,
	input wire logic ext_irq0_in_out,
	input wire logic sleep_mode_in,
	input wire logic wake_out
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] OUT_MASK = (VARIANT == 2'd0) ? `PPR_OUT_MASK_V0 :
		(VARIANT == 2'd1) ? `PPR_OUT_MASK_V1 : `PPR_OUT_MASK_V2;
	// ----------------------------------------------------------------
	// Shadow of the routing registers
	// ----------------------------------------------------------------
	logic [7:0] in_r, out_r, en0_r, en1_r;
	logic [2:0] quiet_r;
	wire logic wr_ok = clk_en_in && reg_wr_in;
	wire logic irq0_src = in_r[`PPR_IN_EXTIRQ0] ? port_pin_in[36] : port_pin_in[3];
	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			in_r <= 8'h00;
			out_r <= 8'h00;
			en0_r <= 8'h00;
			en1_r <= 8'h00;
			quiet_r <= 3'h0;
		end
		else
		begin
			if (wr_ok && reg_addr_in == `PPR_ADDR_IN_REMAP)
				in_r <= reg_wdata_in;
			if (wr_ok && reg_addr_in == `PPR_ADDR_OUT_REMAP)
				out_r <= reg_wdata_in;
			if (wr_ok && reg_addr_in == `PPR_ADDR_TM_EN0)
				en0_r <= reg_wdata_in;
			if (wr_ok && reg_addr_in == `PPR_ADDR_TM_EN1)
				en1_r <= reg_wdata_in;
			// Sync path is three deep, so wait out a remap change
			if (!clk_en_in || (wr_ok && reg_addr_in == `PPR_ADDR_IN_REMAP))
				quiet_r <= 3'h0;
			else if (quiet_r != 3'h7)
				quiet_r <= quiet_r + 3'h1;
		end
	end
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (reset_in);
	sequence s_wr(logic [7:0] a);
		clk_en_in && reg_wr_in && reg_addr_in == a;
	endsequence
	sequence s_rd(logic [7:0] a);
		clk_en_in && reg_rd_in && reg_addr_in == a;
	endsequence
	sequence s_wr_gap_rd(logic [7:0] a);
		s_wr(a) ##1 !reg_wr_in ##1 s_rd(a);
	endsequence
	AST_RESET_PINS: assert property (disable iff (1'b0) reset_in |=> !port_pin_oe_out && &port_pin_out)
		else $error("Pins not inputs with high data after reset");
	AST_REMAP_READBACK: assert property (
		s_wr_gap_rd(`PPR_ADDR_OUT_REMAP) |=> reg_rdata_out == ($past(reg_wdata_in, 3) & OUT_MASK))
		else $error("Output remap read back wrong");
	AST_DIR_H: assert property (s_wr(`PPR_ADDR_DIR_BASE + 8'h07) |=> ##1 port_pin_oe_out[63:56] == ~$past(reg_wdata_in, 2))
		else $error("Port H enables do not follow direction write");
	AST_DATA_H: assert property (
		s_wr(`PPR_ADDR_DATA_BASE + 8'h07) |=> ##1 ((port_pin_out[63:56] ^ $past(reg_wdata_in, 2)) & port_pin_oe_out[63:56]) == 8'h00)
		else $error("Port H drive does not follow data write");
	AST_WAKE_NEEDS_SLEEP: assert property (wake_out && $past(clk_en_in) |-> $past(sleep_mode_in))
		else $error("Wake pulse outside sleep");
	AST_T0_ROUTE: assert property (
		$past(clk_en_in) && $past(en0_r[0]) |->
		($past(out_r[0]) ? {port_pin_oe_out[24], port_pin_out[24]} : {port_pin_oe_out[0], port_pin_out[0]})
		== {1'b1, $past(timer0_out_ch0_in)})
		else $error("Timer 0 channel 0 not on its selected pin");
	AST_T3_ROUTE: assert property (
		VARIANT >= 2'd2 && $past(clk_en_in) && $past(en1_r[1]) |->
		($past(out_r[7]) ? {port_pin_oe_out[41], port_pin_out[41]} : {port_pin_oe_out[48], port_pin_out[48]})
		== {1'b1, $past(timer3_out_ch1_in)})
		else $error("Timer 3 channel 1 not on its selected pin");
	AST_IRQ0_ROUTE: assert property (quiet_r >= 3'h4 |-> ext_irq0_in_out == $past(irq0_src, 3))
		else $error("External interrupt 0 not taken from its selected pin");
endmodule // ppr_pin_remap_chk
bind ppr_pin_remap ppr_pin_remap_chk #(.VARIANT(VARIANT)) u_chk (
	.clk_sys_in(clk_sys_in), .reset_in(reset_in), .clk_en_in(clk_en_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
	.port_pin_in(port_pin_in), .port_pin_out(port_pin_out), .port_pin_oe_out(port_pin_oe_out),
	.timer0_out_ch0_in(timer0_out_ch0_in), .timer3_out_ch1_in(timer3_out_ch1_in),
	.ext_irq0_in_out(ext_irq0_in_out), .sleep_mode_in(sleep_mode_in), .wake_out(wake_out)
);
`default_nettype wire

//--- tb/tb_port_pin_remap_and_io_init.sv
// Self-checking bench of the pin remap block
`default_nettype none
`include "ppr_consts.vh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin error_cnt++; $display("Error at %0t: got %0h expected %0h", $time, got, exp); end end
module tb_port_pin_remap_and_io_init;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_in = 1'b0;
	logic reset_in = 1'b1;
	logic clk_en_in = 1'b1;
	logic [7:0] reg_addr_in = 8'h00;
	logic [7:0] reg_wdata_in = 8'h00;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic sleep_mode_in = 1'b0;
	logic [9:0] tmr = 10'h000;
	logic [63:0] ext_lvl = {64{1'b1}};
	wire logic [7:0] rdata;
	wire logic [63:0] pin_lvl, pin_drv, pin_oe;
	wire logic [5:0] rt;
	wire logic wake;
	wire logic [7:0] rdata_s;
	wire logic [63:0] pin_drv_s, pin_oe_s;
	int error_cnt = 0;
	int compares = 0;
	logic [7:0] got, got_s, ri, ro, e0, e1, pin, kind;
	logic [3:0] wk;
	// Rows: in remap, out remap, enable 0, enable 1, pin, kind (0 timer out, else routed input + 1)
	logic [47:0] rows [32] = '{48'h000001000000, 48'h000101001800, 48'h000002001500, 48'h000202001900,
		48'h000004000100, 48'h000404001a00, 48'h000020001500, 48'h000820001d00, 48'h000040001300,
		48'h001040001e00, 48'h000080001400, 48'h002080001f00, 48'h000000013300, 48'h004000012800,
		48'h000000023000, 48'h008000022900, 48'h000008001000, 48'h010008001b00, 48'h000010001100,
		48'h020010001c00, 48'h000000040201, 48'h200000042001, 48'h000000080402, 48'h400000082102,
		48'h000000101203, 48'h800000102203, 48'h000000000304, 48'h040000002404, 48'h000000000405,
		48'h080000002505, 48'h000000000506, 48'h100000002606};
	always #10 clk_sys_in = ~clk_sys_in;
	ppr_pin_env u_env (.pin_drv_in(pin_drv), .pin_oe_in(pin_oe), .ext_lvl_in(ext_lvl), .pin_lvl_out(pin_lvl));
	ppr_pin_remap DUT (
		.clk_sys_in(clk_sys_in), .reset_in(reset_in), .clk_en_in(clk_en_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(rdata),
		.port_pin_in(pin_lvl), .port_pin_out(pin_drv), .port_pin_oe_out(pin_oe),
		.timer0_out_ch0_in(tmr[0]), .timer0_out_ch1_in(tmr[1]), .timer1_a_out_in(tmr[2]),
		.timer1_b_out_ch0_in(tmr[3]), .timer1_b_out_ch1_in(tmr[4]), .timer1_b_out_ch2_in(tmr[5]),
		.timer2_out_ch0_in(tmr[6]), .timer2_out_ch1_in(tmr[7]), .timer3_out_ch0_in(tmr[8]),
		.timer3_out_ch1_in(tmr[9]), .timer0_clock_in_out(rt[0]), .timer1_clock_in_out(rt[1]),
		.timer2_clock_in_out(rt[2]), .ext_irq0_in_out(rt[3]), .ext_irq1_in_out(rt[4]),
		.ext_irq2_in_out(rt[5]), .sleep_mode_in(sleep_mode_in), .wake_out(wake)
	);
	// Smallest variant beside the default one, for its masks and pin choices
	ppr_pin_remap #(.VARIANT(2'd0)) DUT_SMALL (
		.clk_sys_in(clk_sys_in), .reset_in(reset_in), .clk_en_in(clk_en_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(rdata_s),
		.port_pin_in(ext_lvl), .port_pin_out(pin_drv_s), .port_pin_oe_out(pin_oe_s),
		.timer0_out_ch0_in(tmr[0]), .timer0_out_ch1_in(tmr[1]), .timer1_a_out_in(tmr[2]),
		.timer1_b_out_ch0_in(tmr[3]), .timer1_b_out_ch1_in(tmr[4]), .timer1_b_out_ch2_in(tmr[5]),
		.timer2_out_ch0_in(tmr[6]), .timer2_out_ch1_in(tmr[7]), .timer3_out_ch0_in(tmr[8]),
		.timer3_out_ch1_in(tmr[9]), .timer0_clock_in_out(), .timer1_clock_in_out(),
		.timer2_clock_in_out(), .ext_irq0_in_out(), .ext_irq1_in_out(),
		.ext_irq2_in_out(), .sleep_mode_in(sleep_mode_in), .wake_out()
	);
	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clk_sys_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clk_sys_in);
		reg_rd_in <= 1'b0;
		#1 got = rdata;
		got_s = rdata_s;
		`CHK(got, e)
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask
	task automatic count_wake(output logic [3:0] c);
		c = 4'h0;
		repeat (10)
		begin
			@(posedge clk_sys_in);
			#1 c = c + {3'h0, wake};
		end
	endtask
	task automatic chk_reset();
		for (int p = 0; p < 8; p++)
		begin
			rchk(`PPR_ADDR_DATA_BASE + 8'(p), 8'hff);
			rchk(`PPR_ADDR_DIR_BASE + 8'(p), 8'hff);
		end
		rchk(`PPR_ADDR_IN_REMAP, 8'h00);
		rchk(`PPR_ADDR_OUT_REMAP, 8'h00);
		rchk(8'h40, 8'h00);
		`CHK({pin_oe, pin_drv}, {64'h0, {64{1'b1}}})
	endtask
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (12) @(posedge clk_sys_in);
		reset_in <= 1'b0;
		chk_reset();
		$display("Done: reset values");
		foreach (rows[i])
		begin
			{ri, ro, e0, e1, pin, kind} = rows[i];
			wr(`PPR_ADDR_IN_REMAP, ri);
			wr(`PPR_ADDR_OUT_REMAP, ro);
			wr(`PPR_ADDR_TM_EN0, e0);
			wr(`PPR_ADDR_TM_EN1, e1);
			for (int v = 1; v >= 0; v--)
			begin
				@(posedge clk_sys_in) tmr <= {10{v[0]}};
				ext_lvl <= {64{~v[0]}} ^ (64'h1 << pin[5:0]);
				settle(5);
				if (kind == 8'h00)
					`CHK({pin_oe[pin[5:0]], pin_drv[pin[5:0]], 7'($countones(pin_oe))}, {1'b1, v[0], 7'h01})
				else
					`CHK(rt[kind[2:0] - 3'h1], v[0])
			end
		end
		$display("Done: routing rows");
		wr(`PPR_ADDR_OUT_REMAP, 8'hff);
		rchk(`PPR_ADDR_OUT_REMAP, 8'hff);
		`CHK(got_s, 8'h07)
		wr(`PPR_ADDR_IN_REMAP, 8'hff);
		rchk(`PPR_ADDR_IN_REMAP, 8'hff);
		`CHK(got_s, 8'h6f)
		wr(`PPR_ADDR_IN_REMAP, 8'h00);
		wr(`PPR_ADDR_OUT_REMAP, 8'h00);
		wr(`PPR_ADDR_TM_EN1, 8'h00);
		wr(`PPR_ADDR_TM_EN0, 8'h22);
		@(posedge clk_sys_in) tmr <= 10'h002;
		ext_lvl <= {64{1'b1}};
		settle(5);
		`CHK({pin_drv[21], rt[0]}, 2'b10)
		`CHK({pin_oe_s[7], pin_drv_s[7], pin_oe_s[21]}, 3'b110)
		@(posedge clk_sys_in) tmr <= 10'h020;
		settle(3);
		`CHK(pin_drv[21], 1'b0)
		`CHK(pin_drv_s[7], 1'b0)
		wr(`PPR_ADDR_TM_EN0, 8'h00);
		$display("Done: conflict and enable");
		wr(`PPR_ADDR_DIR_BASE + 8'h02, 8'h0f);
		@(posedge clk_sys_in) ext_lvl <= ~(64'hf << 16);
		settle(4);
		`CHK({pin_oe[23:16], pin_lvl[23:16]}, 16'hf0f0)
		wr(`PPR_ADDR_BITOP, 8'h15);
		rchk(`PPR_ADDR_DATA_BASE + 8'h02, 8'hd0);
		wr(`PPR_ADDR_BITOP, 8'hd7);
		rchk(`PPR_ADDR_DIR_BASE + 8'h02, 8'h8f);
		wr(`PPR_ADDR_DIR_BASE + 8'h07, 8'h0f);
		wr(`PPR_ADDR_DATA_BASE + 8'h07, 8'h5a);
		settle(2);
		`CHK(pin_lvl[63:56], 8'h5f)
		$display("Done: port bit operations");
		wr(`PPR_ADDR_WAKE_EN, 8'h40);
		@(posedge clk_sys_in) sleep_mode_in <= 1'b1;
		@(posedge clk_sys_in) ext_lvl[6] <= 1'b0;
		count_wake(wk);
		`CHK(wk, 4'h1)
		@(posedge clk_sys_in) ext_lvl[7] <= 1'b0;
		count_wake(wk);
		`CHK(wk, 4'h0)
		@(posedge clk_sys_in) sleep_mode_in <= 1'b0;
		ext_lvl[6] <= 1'b1;
		settle(5);
		@(posedge clk_sys_in) ext_lvl[6] <= 1'b0;
		count_wake(wk);
		`CHK(wk, 4'h0)
		// Clock enable low: the write must be lost
		@(posedge clk_sys_in) clk_en_in <= 1'b0;
		wr(`PPR_ADDR_WAKE_EN, 8'h3c);
		clk_en_in <= 1'b1;
		rchk(`PPR_ADDR_WAKE_EN, 8'h40);
		$display("Done: wake-up");
		@(posedge clk_sys_in) reset_in <= 1'b1;
		settle(12);
		@(posedge clk_sys_in) reset_in <= 1'b0;
		chk_reset();
		$display("Done: second reset");
		end_of_test();
	end
	initial
	begin
		#1000000;
		error_cnt++;
		end_of_test();
	end
endmodule // tb_port_pin_remap_and_io_init
`default_nettype wire
